/* File: verilog/qrl_pkg.sv */
// Shared constants for the queued read and log read command interpreter
package qrl_pkg;

  // ************************************************************
  // Command codes and task-file field positions
  // ************************************************************
  localparam logic [7:0] CMD_QREAD        = 8'h60;
  localparam logic [7:0] CMD_LOGRD        = 8'h2F;
  localparam int         TAG_MSB          = 7;
  localparam int         TAG_LSB          = 3;
  localparam int         URGENCY_BIT      = 7;
  localparam int         FORCE_MEDIA_BIT  = 7;
  localparam int         NUM_TAGS         = 32;
  // Highest usable tag, as reported in identify word 75
  localparam logic [4:0] MAX_TAG          = 5'h1F;

  // ************************************************************
  // Flag bit positions
  // ************************************************************
  localparam int ERRB_UNC = 6;
  localparam int ERRB_ABT = 2;
  localparam int STB_BSY  = 7;
  localparam int STB_RDY  = 6;
  localparam int STB_DSC  = 4;
  localparam int STB_ERR  = 0;

  // ************************************************************
  // Log address map and sizes in sectors
  // ************************************************************
  localparam logic [7:0]  LOG_DIR       = 8'h00;
  localparam logic [7:0]  LOG_EXT_ERR   = 8'h03;
  localparam logic [7:0]  LOG_BASIC_ST  = 8'h06;
  localparam logic [7:0]  LOG_EXT_ST    = 8'h07;
  localparam logic [7:0]  LOG_QERR      = 8'h10;
  localparam logic [7:0]  LOG_LINK_EVT  = 8'h11;
  localparam logic [7:0]  LOG_STRM_LO   = 8'h20;
  localparam logic [7:0]  LOG_STRM_HI   = 8'h22;
  localparam logic [7:0]  LOG_HOST_LO   = 8'h80;
  localparam logic [7:0]  LOG_HOST_HI   = 8'h9F;
  localparam logic [16:0] SZ_ONE        = 17'h00001;
  localparam logic [16:0] SZ_EXT_ERR    = 17'h00004;
  localparam logic [16:0] SZ_EXT_ST     = 17'h00001;
  localparam logic [16:0] SZ_STREAM     = 17'h00001;
  localparam logic [16:0] SZ_HOST       = 17'h00010;

  // ************************************************************
  // Controller register byte offsets (AHB-Lite)
  // ************************************************************
  localparam logic [7:0] OFS_CMD     = 8'h00;
  localparam logic [7:0] OFS_FEATCNT = 8'h04;
  localparam logic [7:0] OFS_SECTCYL = 8'h08;
  localparam logic [7:0] OFS_CYLHDEV = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_RESULT  = 8'h14;
  localparam logic [7:0] OFS_TAGS    = 8'h18;
  localparam logic [7:0] OFS_EVENTS  = 8'h1C;
  localparam int         HOB_CTL_BIT = 24;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_LOG  = 3'b100
  } qrl_state_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b01,
    HS_SEND = 2'b10
  } qrl_hstate_e;

endpackage

/* File: verilog/qrl_if.sv */
// Task-file link between host controller and drive command interpreter
`timescale 1ns/100ps
interface qrl_if;
  logic        cmd_valid;
  logic        cmd_ready;
  logic [7:0]  cmd_code;
  logic [15:0] tf_feat;
  logic [15:0] tf_count;
  logic [15:0] tf_sect;
  logic [15:0] tf_cyl_lo;
  logic [15:0] tf_cyl_hi;
  logic [7:0]  tf_devhead;
  logic        high_byte_select;
  logic        rsp_done;
  logic        rsp_queued;
  logic [4:0]  rsp_tag;
  logic [7:0]  err_flags;
  logic [7:0]  cond_flags;
  logic [7:0]  rd_sect;
  logic [7:0]  rd_cyl_lo;
  logic [7:0]  rd_cyl_hi;
  logic        blk_irq;
  logic        xfer_valid;
  logic [47:0] xfer_index;

  modport host (output cmd_valid, cmd_code, tf_feat, tf_count, tf_sect, tf_cyl_lo,
                tf_cyl_hi, tf_devhead, high_byte_select,
                input  cmd_ready, rsp_done, rsp_queued, rsp_tag, err_flags, cond_flags,
                rd_sect, rd_cyl_lo, rd_cyl_hi, blk_irq, xfer_valid, xfer_index);
  modport drive (input  cmd_valid, cmd_code, tf_feat, tf_count, tf_sect, tf_cyl_lo,
                 tf_cyl_hi, tf_devhead, high_byte_select,
                 output cmd_ready, rsp_done, rsp_queued, rsp_tag, err_flags, cond_flags,
                 rd_sect, rd_cyl_lo, rd_cyl_hi, blk_irq, xfer_valid, xfer_index);
endinterface

/* File: verilog/qrl_drive.sv */
// Drive end: decodes queued reads and extended log reads from the task file
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/100ps
module qrl_drive
  import qrl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  qrl_if.drive       lnk,
  output logic       media_req,
  output logic [47:0] media_lba,
  input  wire logic  media_ack,
  input  wire logic  media_uncorr,
  input  wire logic  smart_en,
  input  wire logic  stream_en
);

  // ************************************************************
  // Queue storage
  // ************************************************************
  logic [NUM_TAGS-1:0] busy_r;
  logic [NUM_TAGS-1:0] urgent_r;
  logic [NUM_TAGS-1:0] force_r;
  logic [47:0]         lba_mem [NUM_TAGS];
  logic [16:0]         len_mem [NUM_TAGS];
  qrl_state_e  state_r;
  logic [4:0]  cur_tag_r;
  logic [47:0] cur_idx_r;
  logic [16:0] left_r;
  logic        force_cur_r;
  logic [47:0] err_lba_r;
  logic [7:0]  err_r;
  logic        cache_vld_r;
  logic [47:0] cache_lba_r;
  logic        accept;
  logic [4:0]  new_tag;
  logic        tag_bad;
  logic [16:0] log_size;
  logic        log_bad;
  logic [16:0] log_end;
  logic        have_pick;
  logic [4:0]  pick;
  logic        cache_hit;
  logic        sect_ok;
  logic        sect_fail;
  assign lnk.cmd_ready = (state_r == ST_IDLE);
  assign accept        = lnk.cmd_valid & lnk.cmd_ready;
  assign new_tag       = lnk.tf_count[TAG_MSB:TAG_LSB];
  assign tag_bad       = busy_r[new_tag] | (new_tag > MAX_TAG);
  // ************************************************************
  // Log address decode
  // ************************************************************
  always_comb begin
    log_size = '0;
    unique case (1'b1)
      lnk.tf_sect[7:0] == LOG_DIR:      log_size = SZ_ONE;
      lnk.tf_sect[7:0] == LOG_EXT_ERR:  log_size = smart_en ? SZ_EXT_ERR : '0;
      // Self-test log sized for mixed 48-bit and 28-bit entries
      lnk.tf_sect[7:0] == LOG_EXT_ST:   log_size = smart_en ? SZ_EXT_ST : '0;
      lnk.tf_sect[7:0] == LOG_QERR:     log_size = SZ_ONE;
      lnk.tf_sect[7:0] == LOG_LINK_EVT: log_size = SZ_ONE;
      lnk.tf_sect[7:0] >= LOG_STRM_LO && lnk.tf_sect[7:0] <= LOG_STRM_HI:
        log_size = stream_en ? SZ_STREAM : '0;
      lnk.tf_sect[7:0] >= LOG_HOST_LO && lnk.tf_sect[7:0] <= LOG_HOST_HI:
        log_size = smart_en ? SZ_HOST : '0;
      default: log_size = '0;
    endcase
  end
  // Start sector from cylinder low, count from sector count
  assign log_end = 17'(lnk.tf_cyl_lo) + 17'(lnk.tf_count);
  assign log_bad = (log_size == '0) || (lnk.tf_count == 16'h0000)
                   || (log_end > log_size);
  // ************************************************************
  // Scheduler: urgent tags win, lowest index among equals
  // ************************************************************
  always_comb begin
    have_pick = |busy_r;
    pick      = '0;
    for (int i = NUM_TAGS - 1; i >= 0; i--) begin
      if (busy_r[i] && (urgent_r[i] || !(|(busy_r & urgent_r)))) begin
        pick = 5'(i);
      end
    end
  end
  // One-entry cache of the last sector read from media
  assign cache_hit = cache_vld_r & (cache_lba_r == cur_idx_r) & ~force_cur_r;
  assign sect_ok   = (state_r == ST_READ) & (cache_hit | (media_ack & ~media_uncorr));
  assign sect_fail = (state_r == ST_READ) & ~cache_hit & media_ack & media_uncorr;
  // ************************************************************
  // Queue slot bookkeeping
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r   <= '0;
      urgent_r <= '0;
      force_r  <= '0;
    end else begin
      if (accept && lnk.cmd_code == CMD_QREAD && !tag_bad) begin
        busy_r[new_tag]   <= 1'b1;
        urgent_r[new_tag] <= lnk.tf_count[8 + URGENCY_BIT];
        force_r[new_tag]  <= lnk.tf_devhead[FORCE_MEDIA_BIT];
      end
      if ((state_r == ST_READ) && (sect_fail || (sect_ok && left_r == 17'h00001))) begin
        busy_r[cur_tag_r] <= 1'b0;
      end
    end
  end
  // Arrays are not reset; busy bits guard every read of them
  always_ff @(posedge clk) begin
    if (accept && lnk.cmd_code == CMD_QREAD && !tag_bad) begin
      lba_mem[new_tag] <= {lnk.tf_cyl_hi[15:8], lnk.tf_cyl_lo[15:8], lnk.tf_sect[15:8],
                           lnk.tf_cyl_hi[7:0], lnk.tf_cyl_lo[7:0], lnk.tf_sect[7:0]};
      // Zero count means 65536 sectors
      len_mem[new_tag] <= (lnk.tf_feat == 16'h0000) ? 17'h10000 : 17'(lnk.tf_feat);
    end
  end
  // ************************************************************
  // Execution state machine
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      cur_tag_r   <= '0;
      cur_idx_r   <= '0;
      left_r      <= '0;
      force_cur_r <= 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (accept && lnk.cmd_code == CMD_LOGRD && !log_bad) begin
            state_r   <= ST_LOG;
            cur_idx_r <= {32'h00000000, lnk.tf_cyl_lo};
            left_r    <= 17'(lnk.tf_count);
          end else if (!accept && have_pick) begin
            state_r     <= ST_READ;
            cur_tag_r   <= pick;
            cur_idx_r   <= lba_mem[pick];
            left_r      <= len_mem[pick];
            force_cur_r <= force_r[pick];
          end
        end
        ST_READ: begin
          if (sect_fail) begin
            state_r <= ST_IDLE;
          end else if (sect_ok) begin
            cur_idx_r <= cur_idx_r + 48'h000000000001;
            left_r    <= left_r - 17'h00001;
            if (left_r == 17'h00001) begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_LOG: begin
          cur_idx_r <= cur_idx_r + 48'h000000000001;
          left_r    <= left_r - 17'h00001;
          if (left_r == 17'h00001) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end
  // ************************************************************
  // Media port and cache
  // ************************************************************
  assign media_req = (state_r == ST_READ) & ~cache_hit & ~media_ack;
  assign media_lba = cur_idx_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cache_vld_r <= 1'b0;
      cache_lba_r <= '0;
    end else if ((state_r == ST_READ) && !cache_hit && media_ack) begin
      cache_vld_r <= ~media_uncorr;
      cache_lba_r <= cur_idx_r;
    end
  end
  // ************************************************************
  // Responses, data events and error reporting
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lnk.rsp_done   <= 1'b0;
      lnk.rsp_queued <= 1'b0;
      lnk.rsp_tag    <= '0;
      lnk.blk_irq    <= 1'b0;
      lnk.xfer_valid <= 1'b0;
      lnk.xfer_index <= '0;
      err_r          <= '0;
      err_lba_r      <= '0;
    end else begin
      lnk.rsp_done   <= 1'b0;
      lnk.rsp_queued <= 1'b0;
      lnk.blk_irq    <= 1'b0;
      lnk.xfer_valid <= 1'b0;
      if (accept) begin
        err_r <= '0;
        if ((lnk.cmd_code == CMD_QREAD && tag_bad)
            || (lnk.cmd_code == CMD_LOGRD && log_bad)
            || (lnk.cmd_code != CMD_QREAD && lnk.cmd_code != CMD_LOGRD)) begin
          err_r[ERRB_ABT] <= 1'b1;
          lnk.rsp_done    <= 1'b1;
          lnk.rsp_tag     <= new_tag;
        end
      end
      if (sect_ok || state_r == ST_LOG) begin
        lnk.xfer_valid <= 1'b1;
        lnk.xfer_index <= cur_idx_r;
      end
      if (state_r == ST_LOG) begin
        lnk.blk_irq <= 1'b1;
        if (left_r == 17'h00001) begin
          lnk.rsp_done <= 1'b1;
        end
      end
      if (sect_fail) begin
        err_r           <= 8'h00;
        err_r[ERRB_UNC] <= 1'b1;
        err_lba_r       <= cur_idx_r;
      end
      if (sect_fail || (sect_ok && left_r == 17'h00001)) begin
        lnk.rsp_done   <= 1'b1;
        lnk.rsp_queued <= 1'b1;
        lnk.rsp_tag    <= cur_tag_r;
      end
    end
  end
  // Failing address bytes, high half shown when select is set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lnk.rd_sect    <= '0;
      lnk.rd_cyl_lo  <= '0;
      lnk.rd_cyl_hi  <= '0;
      lnk.cond_flags <= '0;
      lnk.err_flags  <= '0;
    end else begin
      lnk.rd_sect   <= lnk.high_byte_select ? err_lba_r[31:24] : err_lba_r[7:0];
      lnk.rd_cyl_lo <= lnk.high_byte_select ? err_lba_r[39:32] : err_lba_r[15:8];
      lnk.rd_cyl_hi <= lnk.high_byte_select ? err_lba_r[47:40] : err_lba_r[23:16];
      lnk.err_flags <= err_r;
      lnk.cond_flags          <= '0;
      lnk.cond_flags[STB_BSY] <= (state_r == ST_LOG);
      lnk.cond_flags[STB_RDY] <= 1'b1;
      lnk.cond_flags[STB_DSC] <= 1'b1;
      lnk.cond_flags[STB_ERR] <= |err_r;
    end
  end

endmodule

/* File: verilog/qrl_host.sv */
// Host end: AHB-Lite register front that issues task-file commands
`timescale 1ns/100ps
module qrl_host
  import qrl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  qrl_if.host        lnk,
  input  wire logic  hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic  hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic  hready,
  output logic [31:0] hrdata,
  output logic       hreadyout,
  output logic       hresp
);

  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] feat_cnt_r;
  logic [31:0] sect_cyl_r;
  logic [24:0] cylh_dev_r;
  logic [7:0]  code_r;
  logic        refused_r;
  logic [NUM_TAGS-1:0] outst_r;
  logic [15:0] blk_cnt_r;
  logic [4:0]  last_tag_r;
  qrl_hstate_e hst_r;
  logic        addr_ph;
  logic        cmd_wr;
  logic [4:0]  req_tag;
  logic        req_bad;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ph   = hsel & htrans[1] & hready;
  assign cmd_wr    = wr_pend_r & (wr_addr_r == OFS_CMD);
  assign req_tag   = feat_cnt_r[16 + TAG_MSB:16 + TAG_LSB];
  // Refuse a queued read whose tag is in use or beyond queue depth
  assign req_bad   = (hwdata[7:0] == CMD_QREAD)
                     & (outst_r[req_tag] | (req_tag > MAX_TAG));

  // ************************************************************
  // Bus slave, zero wait states
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_r  <= 1'b0;
      wr_addr_r  <= '0;
      hrdata     <= '0;
      feat_cnt_r <= '0;
      sect_cyl_r <= '0;
      cylh_dev_r <= '0;
    end else begin
      wr_pend_r <= addr_ph & hwrite;
      wr_addr_r <= {haddr[7:2], 2'b00};
      if (addr_ph && !hwrite) begin
        unique case ({haddr[7:2], 2'b00})
          OFS_FEATCNT: hrdata <= feat_cnt_r;
          OFS_SECTCYL: hrdata <= sect_cyl_r;
          OFS_CYLHDEV: hrdata <= {7'h00, cylh_dev_r};
          OFS_STATUS:  hrdata <= {14'h0000, refused_r, hst_r == HS_SEND,
                                  lnk.err_flags, lnk.cond_flags};
          OFS_RESULT:  hrdata <= {3'h0, last_tag_r, lnk.rd_cyl_hi, lnk.rd_cyl_lo, lnk.rd_sect};
          OFS_TAGS:    hrdata <= outst_r;
          OFS_EVENTS:  hrdata <= {16'h0000, blk_cnt_r};
          default:     hrdata <= '0;
        endcase
      end
      if (wr_pend_r) begin
        unique case (wr_addr_r)
          OFS_FEATCNT: feat_cnt_r <= hwdata;
          OFS_SECTCYL: sect_cyl_r <= hwdata;
          OFS_CYLHDEV: cylh_dev_r <= hwdata[24:0];
          default: ;
        endcase
      end
    end
  end

  // ************************************************************
  // Command issue and outstanding tag tracking
  // ************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hst_r      <= HS_IDLE;
      code_r     <= '0;
      refused_r  <= 1'b0;
      outst_r    <= '0;
      blk_cnt_r  <= '0;
      last_tag_r <= '0;
    end else begin
      if (hst_r == HS_IDLE && cmd_wr) begin
        refused_r <= req_bad;
        code_r    <= hwdata[7:0];
        if (!req_bad) begin
          hst_r <= HS_SEND;
        end
      end else if (hst_r == HS_SEND && lnk.cmd_ready) begin
        hst_r <= HS_IDLE;
      end
      if (lnk.rsp_done) begin
        last_tag_r <= lnk.rsp_tag;
      end
      if (lnk.rsp_done && lnk.rsp_queued) begin
        outst_r[lnk.rsp_tag] <= 1'b0;
      end
      // Set after clear so a same-cycle reissue is kept
      if (hst_r == HS_SEND && lnk.cmd_ready && code_r == CMD_QREAD) begin
        outst_r[req_tag] <= 1'b1;
      end
      if (lnk.blk_irq) begin
        blk_cnt_r <= blk_cnt_r + 16'h0001;
      end
    end
  end

  assign lnk.cmd_valid        = (hst_r == HS_SEND);
  assign lnk.cmd_code         = code_r;
  assign lnk.tf_feat          = feat_cnt_r[15:0];
  assign lnk.tf_count         = feat_cnt_r[31:16];
  assign lnk.tf_sect          = sect_cyl_r[15:0];
  assign lnk.tf_cyl_lo        = sect_cyl_r[31:16];
  assign lnk.tf_cyl_hi        = cylh_dev_r[15:0];
  assign lnk.tf_devhead       = cylh_dev_r[23:16];
  assign lnk.high_byte_select = cylh_dev_r[HOB_CTL_BIT];

endmodule

/* File: verif/qrl_checker.sv */
// Assertions on the task-file link between host and drive ends
`timescale 1ns/100ps
module qrl_checker
  import qrl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [7:0]  cmd_code,
  input wire logic [15:0] tf_count,
  input wire logic [15:0] tf_sect,
  input wire logic [15:0] tf_cyl_lo,
  input wire logic        rsp_done,
  input wire logic        rsp_queued,
  input wire logic [7:0]  err_flags,
  input wire logic        blk_irq,
  input wire logic        xfer_valid,
  input wire logic [47:0] xfer_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // Accept events and transfer steps
  // ************************************************************
  logic acc;
  logic lacc;
  assign acc  = cmd_valid && cmd_ready;
  assign lacc = acc && (cmd_code == CMD_LOGRD);

  sequence dir_acc_s;
    lacc && tf_sect[7:0] == LOG_DIR && tf_count == 16'h0001 && tf_cyl_lo == 16'h0000;
  endsequence
  sequence dir_deliver_s;
    xfer_valid && blk_irq && rsp_done && xfer_index == 48'h0;
  endsequence
  sequence aborted_s;
    rsp_done && !xfer_valid && !rsp_queued;
  endsequence

  // ************************************************************
  // Properties
  // ************************************************************
  unknown_abort_a: assert property (
    acc && cmd_code != CMD_QREAD && cmd_code != CMD_LOGRD |=> aborted_s)
    else $error("unknown command not aborted");
  queued_pair_a: assert property (rsp_queued |-> rsp_done)
    else $error("queued completion without done");
  qread_no_early_a: assert property (
    acc && cmd_code == CMD_QREAD |=> !rsp_done)
    else $error("queued read answered at accept");
  log_dir_walk_a: assert property (dir_acc_s |-> ##1 !cmd_ready ##1 dir_deliver_s)
    else $error("directory read walk wrong");
  irq_with_block_a: assert property (blk_irq |-> xfer_valid)
    else $error("block interrupt without block");
  log06_abort_a: assert property (
    lacc && tf_sect[7:0] == LOG_BASIC_ST |=> aborted_s ##[0:2] err_flags[ERRB_ABT])
    else $error("log 06h not aborted");
  zero_count_abort_a: assert property (lacc && tf_count == 16'h0000 |=> aborted_s)
    else $error("zero count log read not aborted");
  log_start_a: assert property (
    lacc ##2 xfer_valid |-> xfer_index[15:0] == $past(tf_cyl_lo, 2))
    else $error("log did not start at requested sector");
  log_step_a: assert property (
    xfer_valid && blk_irq && !rsp_done |=> xfer_valid && xfer_index == $past(xfer_index) + 1)
    else $error("log blocks not consecutive");
endmodule

/* File: verif/queued_read_and_log_read_cmds_bench.sv */
// Self-checking bench for the queued read and log read ends
`timescale 1ns/100ps
module queued_read_and_log_read_cmds_bench
  import qrl_pkg::*;
();
  localparam logic [47:0] LBA = 48'h6655_4433_2211;
  localparam logic [47:0] BAD = 48'h6655_4433_2312;
  logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s, t;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, media_req, hold = 1'b0;
  logic        media_ack = 1'b0, media_uncorr = 1'b0, smart_en = 1'b0, stream_en = 1'b0;
  logic [47:0] media_lba, last_lba, first_idx, bad_lba = BAD;
  int          errors = 0, samples_checked = 0, n_media = 0, nx = 0, cyc = 0, k;
  logic [31:0] tab [8] = '{32'h0601_0007, 32'h8001_0003, 32'h2101_0005, 32'h2101_0006,
                           32'h8001_1007, 32'h8000_0007, 32'h1001_0000, 32'h8001_0F06};

  qrl_if lnk ();
  qrl_host i_qrl_host (.clk(clk), .rst(rst), .lnk(lnk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  qrl_drive i_qrl_drive (.clk(clk), .rst(rst), .lnk(lnk), .media_req(media_req),
    .media_lba(media_lba), .media_ack(media_ack), .media_uncorr(media_uncorr),
    .smart_en(smart_en), .stream_en(stream_en));
  qrl_checker i_qrl_checker (.clk(clk), .rst(rst), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready), .cmd_code(lnk.cmd_code), .tf_count(lnk.tf_count),
    .tf_sect(lnk.tf_sect), .tf_cyl_lo(lnk.tf_cyl_lo), .rsp_done(lnk.rsp_done),
    .rsp_queued(lnk.rsp_queued), .err_flags(lnk.err_flags), .blk_irq(lnk.blk_irq),
    .xfer_valid(lnk.xfer_valid), .xfer_index(lnk.xfer_index));

  always #10 clk = ~clk;

  // ************************************************************
  // Media stand-in; hold stalls it to keep a tag outstanding
  // ************************************************************
  always @(posedge clk) begin
    media_ack    <= media_req && !media_ack && !hold;
    media_uncorr <= media_req && !media_ack && !hold && media_lba == bad_lba;
    if (media_req && !media_ack && !hold) begin
      n_media  <= n_media + 1;
      last_lba <= media_lba;
    end
    if (lnk.xfer_valid) begin
      if (nx == 0) first_idx <= lnk.xfer_index;
      nx <= nx + 1;
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors++;
      end_sim();
    end
  end

  // ************************************************************
  // Bus and command tasks
  // ************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] f, n, sc, cl,
                     input logic [31:0] w3);
    wr(OFS_FEATCNT, {n, f});
    wr(OFS_SECTCYL, {cl, sc});
    wr(OFS_CYLHDEV, w3);
    wr(OFS_CMD, {24'h0, c});
  endtask
  task automatic qread(input logic [4:0] tg, input logic u, fu, input logic [15:0] n,
                       input logic [47:0] l);
    cmd(CMD_QREAD, n, {u, 7'h0, tg, 3'h0}, {l[31:24], l[7:0]}, {l[39:32], l[15:8]},
        {8'h0, fu, 7'h0, l[47:40], l[23:16]});
  endtask
  task automatic logrd(input logic [7:0] la, input logic [15:0] n, st);
    cmd(CMD_LOGRD, 16'h0, n, {8'h0, la}, st, 32'h0);
  endtask
  // Polls until nothing pending, busy or outstanding
  task automatic settle();
    int i;
    repeat (4) @(posedge clk);
    for (i = 0; i < 200; i++) begin
      rd(OFS_STATUS, s);
      rd(OFS_TAGS, t);
      if (s[16] === 1'b0 && s[7] === 1'b0 && t === 32'h0) break;
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    qread(5'h05, 1'b0, 1'b1, 16'h0002, LBA);
    settle();
    chk("media reads", 48'h2, 48'(n_media));
    chk("last lba", LBA + 48'h1, last_lba);
    rd(OFS_RESULT, s);
    chk("done tag", 48'h05, 48'(s[28:24]));
    qread(5'h06, 1'b1, 1'b1, 16'h0001, LBA + 48'h1);
    settle();
    chk("forced read", 48'h3, 48'(n_media));
    qread(5'h02, 1'b0, 1'b1, 16'h0003, LBA + 48'h100);
    settle();
    chk("stop at bad", 48'h5, 48'(n_media));
    chk("uncorrectable", 48'h1, 48'(s[8 + ERRB_UNC]));
    rd(OFS_RESULT, s);
    chk("bad low", 48'(BAD[23:0]), 48'(s[23:0]));
    wr(OFS_CYLHDEV, 32'h0100_0000);
    // Result bytes follow the select a cycle later
    @(posedge clk);
    rd(OFS_RESULT, s);
    chk("bad high", 48'(BAD[47:24]), 48'(s[23:0]));
    nx = 0;
    logrd(LOG_DIR, 16'h0001, 16'h0000);
    settle();
    rd(OFS_EVENTS, s);
    chk("irq count", 48'h1, 48'(s[15:0]));
    chk("dir index", 48'h0, first_idx);
    smart_en <= 1'b1;
    nx = 0;
    logrd(LOG_HOST_LO, 16'h0003, 16'h0002);
    settle();
    rd(OFS_EVENTS, s);
    chk("irq count", 48'h4, 48'(s[15:0]));
    chk("first index", 48'h2, first_idx);
    chk("blocks", 48'h3, 48'(nx));
    for (k = 0; k < 8; k++) begin
      smart_en  <= tab[k][2];
      stream_en <= tab[k][1];
      logrd(tab[k][31:24], {8'h0, tab[k][23:16]}, {8'h0, tab[k][15:8]});
      settle();
      chk("log abort", 48'(tab[k][0]), 48'(s[8 + ERRB_ABT]));
    end
    cmd(8'hC8, 16'h0, 16'h0, 16'h0, 16'h0, 32'h0);
    settle();
    chk("unknown abort", 48'h1, 48'(s[8 + ERRB_ABT]));
    hold <= 1'b1;
    qread(5'h1F, 1'b0, 1'b1, 16'h0001, LBA);
    repeat (8) @(posedge clk);
    rd(OFS_TAGS, t);
    chk("outstanding", 48'h8000_0000, 48'(t));
    qread(5'h1F, 1'b0, 1'b1, 16'h0001, LBA);
    rd(OFS_STATUS, s);
    chk("tag refused", 48'h1, 48'(s[17]));
    hold <= 1'b0;
    settle();
    chk("tags freed", 48'h0, 48'(t));
    end_sim();
  end
endmodule
